// file: shared/fbwm_consts.svh
// Constants for the bursting write master
`ifndef FBWM_CONSTS_SVH
`define FBWM_CONSTS_SVH
`define FBWM_ADDR_W      32
`define FBWM_DATA_W      32
`define FBWM_LEN_W       32
`define FBWM_BCNT_W      4
`define FBWM_MAX_BURST   8
`define FBWM_WORD_BYTES  4
`define FBWM_FIFO_DEPTH  32
`define FBWM_USED_W      6
`define FBWM_BE_ALL      4'hF
`endif

// file: shared/fbwm_pkg.sv
// Types shared by the bursting write master files
package fbwm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LAUNCH,
    ST_BURST
  } fbwm_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  burstcount;
    logic [3:0]  byteenable;
    logic        write;
    logic [31:0] writedata;
  } fbwm_bus_req_s;
endpackage

// file: rtl/fbwm_skid.sv
// Two-entry buffer between the data FIFO and the bus write data path
`timescale 1ns/1ps
module fbwm_skid #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic         rd_q, rd_d, wr_q, wr_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  // Full and empty are honest: ready drops only with two words held
  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
    end
    wr_d  = push ? ~wr_q : wr_q;
    rd_d  = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  // Register stage
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: rtl/fbwm_master.sv
// Bursting write master draining a local FIFO to sequential memory words
// Operation
// [R1] Start command captures start address and length before any bus activity.
// [R2] Burst launch pulses one clock after start, loading bus address and count.
// [R3] Address, byteenable and burstcount stay fixed through the whole burst.
// [R4] A burst starts only when the FIFO holds enough words for it.
// [R5] Once bursting, write data stalls only for waitrequest, never for data.
// [R6] Each accepted word advances address and reduces length; bus address fixed.
// [R7] A final burst shorter than maximum is detected and ends the transfer.
// [R8] Whole-word writes only, to consecutive rising addresses from the start.
// [R9] Arbiter keeps a master posting a burst of N granted for N writes.
// [R10] Lock holds others out during a burst, so the master must sustain it.
// [R11] Post a burst only when all its words are ready.
// [R12] Bursts cover sequential addresses; a new address needs a new burst.
// [R13] Arbiter gives each master one share by default, more if configured.
// [R14] Arbiter passes grant round robin when the holder cannot post.
// [R15] Interconnect splits bursts longer than the slave supports.
// [R16] Done flag rises after the last word is accepted; clears on next start.
`timescale 1ns/1ps
`include "fbwm_consts.svh"
module fbwm_master #(
  parameter int AW        = `FBWM_ADDR_W,
  parameter int DW        = `FBWM_DATA_W,
  parameter int LW        = `FBWM_LEN_W,
  parameter int BW        = `FBWM_BCNT_W,
  parameter int MAX_BURST = `FBWM_MAX_BURST,
  parameter int UW        = `FBWM_USED_W
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // Control interface
  input  wire logic                 go_i,
  input  wire logic [AW-1:0]        start_addr_i,
  input  wire logic [LW-1:0]        xfer_len_i,
  output logic                      done_o,
  output logic                      busy_o,
  // Local data FIFO read side
  input  wire logic [DW-1:0]        fifo_data_i,
  input  wire logic [UW-1:0]        fifo_used_i,
  input  wire logic                 fifo_empty_i,
  output logic                      fifo_rd_o,
  // Memory-mapped bus master
  output logic [AW-1:0]             m_address_o,
  output logic [BW-1:0]             m_burstcount_o,
  output logic [DW/8-1:0]           m_byteenable_o,
  output logic                      m_write_o,
  output logic [DW-1:0]             m_writedata_o,
  input  wire logic                 m_waitrequest_i
);
  localparam logic [LW-1:0] WORD_B = LW'(`FBWM_WORD_BYTES);
  localparam logic [BW-1:0] MAXB   = BW'(MAX_BURST);

  fbwm_pkg::fbwm_state_e state_q, state_d;
  logic [AW-1:0] addr_q, addr_d;       // Next word address
  logic [LW-1:0] len_q, len_d;         // Remaining bytes
  logic [AW-1:0] baddr_q, baddr_d;     // Bus address, held per burst
  logic [BW-1:0] bcnt_q, bcnt_d;       // Bus burst count, held per burst
  logic [BW-1:0] left_q, left_d;       // Words still owed in this burst
  logic [BW-1:0] ahead_q, ahead_d;     // Words still to pull from the FIFO into the buffer
  logic          done_q, done_d;
  logic          burst_begin;
  logic [LW-1:0] words_left;
  logic [BW-1:0] next_bcnt;
  logic          enough;
  logic          buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [DW-1:0] buf_data;
  logic          accept;
  fbwm_pkg::fbwm_bus_req_s bus_req;    // Bus request carrier

  // Word count of what remains, and the size of the next burst
  assign words_left = len_q >> 2;
  // [R7] Short final burst
  assign next_bcnt  = (words_left < LW'(MAX_BURST)) ? BW'(words_left) : MAXB;
  // [R4] Enough buffered
  assign enough     = (LW'(fifo_used_i) >= LW'(next_bcnt)) && (next_bcnt != '0);
  assign burst_begin = (state_q == fbwm_pkg::ST_LAUNCH) && enough && (len_q != '0);

  // Pull FIFO words into the buffer only for the burst in flight
  // [R10] Sustain locked burst
  // Empty guard keeps a lagging fill count from popping an empty FIFO
  assign buf_in_valid = (state_q == fbwm_pkg::ST_BURST) && (ahead_q != '0) && !fifo_empty_i;
  assign fifo_rd_o    = buf_in_valid && buf_in_ready;
  // [R5] Stall only on waitrequest
  assign accept        = m_write_o && !m_waitrequest_i;
  assign buf_out_ready = (state_q == fbwm_pkg::ST_BURST) && !m_waitrequest_i;

  fbwm_skid #(
    .W (DW)
  ) u_skid (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (fifo_data_i),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_data)
  );

  // Bus fields: address and count come from flip-flops held per burst
  assign bus_req.addr       = baddr_q;
  assign bus_req.burstcount = bcnt_q;
  // [R8] Whole-word writes
  assign bus_req.byteenable = (state_q == fbwm_pkg::ST_BURST) ? `FBWM_BE_ALL : 4'h0;
  assign bus_req.write      = (state_q == fbwm_pkg::ST_BURST) && buf_out_valid;
  assign bus_req.writedata  = buf_data;
  // Carrier unpacked onto the ports
  assign m_address_o    = bus_req.addr;
  assign m_burstcount_o = bus_req.burstcount;
  assign m_byteenable_o = bus_req.byteenable;
  assign m_write_o      = bus_req.write;
  assign m_writedata_o  = bus_req.writedata;
  assign done_o         = done_q;
  assign busy_o         = (state_q != fbwm_pkg::ST_IDLE);

  // Control state next values
  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    len_d   = len_q;
    baddr_d = baddr_q;
    bcnt_d  = bcnt_q;
    left_d  = left_q;
    ahead_d = ahead_q;
    done_d  = done_q;
    case (state_q)
      fbwm_pkg::ST_IDLE: begin
        if (go_i) begin
          // [R1] Capture address and length
          addr_d  = start_addr_i;
          len_d   = xfer_len_i;
          // [R16] Clear done on start
          done_d  = 1'b0;
          state_d = fbwm_pkg::ST_LAUNCH;
        end
      end
      fbwm_pkg::ST_LAUNCH: begin
        if (len_q == '0) begin
          // [R7] Transfer finished
          done_d  = 1'b1;
          state_d = fbwm_pkg::ST_IDLE;
        end else if (burst_begin) begin
          // [R2] Launch loads bus address and count
          // [R11] Whole burst is ready
          // [R12] New base for each burst
          baddr_d = addr_q;
          bcnt_d  = next_bcnt;
          left_d  = next_bcnt;
          ahead_d = next_bcnt;
          state_d = fbwm_pkg::ST_BURST;
        end
      end
      fbwm_pkg::ST_BURST: begin
        if (fifo_rd_o) begin
          ahead_d = ahead_q - BW'(1);
        end
        if (accept) begin
          // [R6] Advance address, reduce length
          addr_d = addr_q + AW'(WORD_B);
          len_d  = len_q - WORD_B;
          left_d = left_q - BW'(1);
          if (left_q == BW'(1)) begin
            state_d = fbwm_pkg::ST_LAUNCH;
            // [R16] Done after last word accepted
            if (len_q == WORD_B) begin
              done_d  = 1'b1;
              state_d = fbwm_pkg::ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_d = fbwm_pkg::ST_IDLE;
      end
    endcase
  end

  // Control state registers; bus fields change only at launch
  // [R3] Held through burst
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= fbwm_pkg::ST_IDLE;
      addr_q  <= '0;
      len_q   <= '0;
      baddr_q <= '0;
      bcnt_q  <= '0;
      left_q  <= '0;
      ahead_q <= '0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      len_q   <= len_d;
      baddr_q <= baddr_d;
      bcnt_q  <= bcnt_d;
      left_q  <= left_d;
      ahead_q <= ahead_d;
      done_q  <= done_d;
    end
  end
endmodule

// file: bench/fbwm_checker.sv
// Port checker for the bursting write master
`timescale 1ns/1ps
module fbwm_checker (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_i,
  // Watched ports
  input wire logic        go_i,
  input wire logic        done_o,
  input wire logic        busy_o,
  input wire logic [5:0]  fifo_used_i,
  input wire logic [31:0] m_address_o,
  input wire logic [3:0]  m_burstcount_o,
  input wire logic [3:0]  m_byteenable_o,
  input wire logic        m_write_o,
  input wire logic [31:0] m_writedata_o,
  input wire logic        m_waitrequest_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Helper: words accepted so far in the current burst
  logic [3:0] beat_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      beat_q <= 4'h0;
    end else if (m_write_o && !m_waitrequest_i) begin
      beat_q <= (beat_q + 4'h1 == m_burstcount_o) ? 4'h0 : beat_q + 4'h1;
    end
  end
  // Accepted word that is not the last of its burst
  sequence s_mid;
    m_write_o && !m_waitrequest_i && (beat_q + 4'h1 != m_burstcount_o);
  endsequence
  property p_sustain; s_mid |=> m_write_o; endproperty
  a_sustain: assert property (p_sustain) else $error("write gap in burst");
  // Accepted start, stalled word, at least a maximum burst buffered just after start
  sequence s_go; go_i && !busy_o; endsequence
  sequence s_stall; m_write_o && m_waitrequest_i; endsequence
  sequence s_full; s_go ##1 fifo_used_i >= 6'h08; endsequence
  property p_take; s_go |=> busy_o && !done_o; endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_launch; s_full |=> m_byteenable_o == 4'hF; endproperty
  a_launch: assert property (p_launch) else $error("late launch");
  property p_hold;
    s_stall |=> m_write_o && $stable(m_address_o) && $stable(m_burstcount_o)
      && $stable(m_writedata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("burst fields moved");
  property p_used;
    busy_o && $changed(m_address_o) |-> $past(fifo_used_i) >= 6'(m_burstcount_o);
  endproperty
  a_used: assert property (p_used) else $error("burst without data");
  property p_be; m_write_o |-> m_byteenable_o == 4'hF && busy_o; endproperty
  a_be: assert property (p_be) else $error("partial word");
  property p_bc; m_write_o |-> m_burstcount_o inside {[4'h1:4'h8]}; endproperty
  a_bc: assert property (p_bc) else $error("bad burst count");
  property p_done; done_o |-> !busy_o && !m_write_o; endproperty
  a_done: assert property (p_done) else $error("done while busy");
  property p_end; $fell(busy_o) |-> done_o; endproperty
  a_end: assert property (p_end) else $error("end without done");
endmodule
bind fbwm_master fbwm_checker i_fbwm_checker (.mclk_i, .rst_i, .go_i, .done_o, .busy_o,
  .fifo_used_i, .m_address_o, .m_burstcount_o, .m_byteenable_o, .m_write_o,
  .m_writedata_o, .m_waitrequest_i);

// file: bench/fbwm_slave_model.sv
// Slave memory with optional stalls on the master's write bus
`timescale 1ns/1ps
module fbwm_slave_model (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Write bus
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  bcnt_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] data_i,
  // Stall mode and answer
  input  wire logic        slow_i,
  output logic             wait_o
);
  logic [31:0] mem [0:255];
  logic [3:0]  beat_q;
  // Sole master holds the grant, no split
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      beat_q <= 4'h0;
      wait_o <= 1'b1;
    end else begin
      if (wr_i && !wait_o) begin
        mem[addr_i[9:2] + 8'(beat_q)] <= data_i;
        beat_q <= (beat_q + 4'h1 == bcnt_i) ? 4'h0 : beat_q + 4'h1;
      end
      // Alternate stalls so the two-entry buffer must absorb them
      wait_o <= #1 slow_i ? !wait_o : 1'b0;
    end
  end
endmodule

// file: bench/tb.sv
// Self-checking bench for the bursting write master
`timescale 1ns/1ps
module tb;
  logic        mclk_i, rst_i, go_i, done_o, busy_o, fifo_empty_i, fifo_rd_o;
  logic        m_write_o, m_waitrequest_i, slow;
  logic [31:0] start_addr_i, xfer_len_i, fifo_data_i, m_address_o, m_writedata_o;
  logic [5:0]  fifo_used_i;
  logic [3:0]  m_burstcount_o, m_byteenable_o;
  logic [31:0] fq[$];
  int          error_cnt, n_checks, cyc;
  fbwm_master i_fbwm_master (.mclk_i, .rst_i, .go_i, .start_addr_i, .xfer_len_i, .done_o,
    .busy_o, .fifo_data_i, .fifo_used_i, .fifo_empty_i, .fifo_rd_o, .m_address_o,
    .m_burstcount_o, .m_byteenable_o, .m_write_o, .m_writedata_o, .m_waitrequest_i);
  fbwm_slave_model i_fbwm_slave_model (.mclk_i, .rst_i, .addr_i(m_address_o),
    .bcnt_i(m_burstcount_o), .wr_i(m_write_o), .data_i(m_writedata_o), .slow_i(slow),
    .wait_o(m_waitrequest_i));
  // 200 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Show-ahead FIFO outputs; an empty head shows inverted junk, not stale data
  task automatic upd;
    fifo_used_i = 6'(fq.size());
    fifo_empty_i = fq.size() == 0;
    fifo_data_i = fq.size() ? fq[0] : ~fifo_data_i;
  endtask
  // Pop sampled at the edge, applied just after; hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (fifo_rd_o === 1'b1) begin
      #1 void'(fq.pop_front());
      upd();
    end
    if (cyc == 2000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Word k of a run carries the run tag and its index
  task automatic feed(int n, logic [7:0] s);
    repeat (n) fq.push_back({s, 24'(fq.size())});
    upd();
  endtask
  task automatic start(logic [31:0] a, logic [31:0] len);
    @(posedge mclk_i) #1;
    go_i = 1'b1;
    start_addr_i = a;
    xfer_len_i = len;
    @(posedge mclk_i) #1;
    go_i = 1'b0;
  endtask
  task automatic wait_done;
    for (int i = 0; i < 400 && done_o !== 1'b1; i++) @(posedge mclk_i) #1;
    chk("done", 32'h1, done_o);
    chk("busy", 32'h0, busy_o);
    chk("fifo left", 32'h0, fifo_used_i);
  endtask
  task automatic chk_mem(logic [7:0] ix, int n, logic [7:0] s);
    for (int k = 0; k < n; k++) chk("mem", {s, 24'(k)}, i_fbwm_slave_model.mem[ix + 8'(k)]);
  endtask
  // Short single burst at a nonzero base
  task automatic t_short;
    feed(3, 8'hA1);
    start(32'h40, 32'hC);
    chk("busy", 32'h1, busy_o);
    wait_done();
    chk_mem(8'h10, 3, 8'hA1);
  endtask
  // Three bursts under stalls, with a start while busy that must be ignored
  task automatic t_long;
    slow = 1'b1;
    feed(19, 8'hB2);
    start(32'h100, 32'h4C);
    chk("done clear", 32'h0, done_o);
    start(32'h200, 32'h4);
    wait_done();
    chk_mem(8'h40, 19, 8'hB2);
    chk("last base", 32'h140, m_address_o);
    chk("last count", 32'h3, m_burstcount_o);
    slow = 1'b0;
  endtask
  // Too few words buffered: no write until the burst can be filled
  task automatic t_starve;
    feed(2, 8'hC3);
    start(32'h80, 32'hC);
    repeat (10) begin
      @(posedge mclk_i) #1;
      chk("early write", 32'h0, m_write_o);
    end
    feed(1, 8'hC3);
    wait_done();
    chk_mem(8'h20, 3, 8'hC3);
  endtask
  task automatic finish_test;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reset for 10 cycles, then the scenarios
  initial begin
    go_i = 1'b0;
    slow = 1'b0;
    start_addr_i = 32'h0;
    xfer_len_i = 32'h0;
    fifo_data_i = 32'h0;
    upd();
    rst_i = 1'b1;
    repeat (10) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    t_short();
    t_long();
    t_starve();
    finish_test();
  end
endmodule
